// ===== shared/tfbf_pkg.sv
// Purpose: Shared constants and types for the transceiver control logic
// Assumes: 20 MHz system clock, serial clock from the master
// Notes:   Control bit positions, control and diagnosis reset words, modes, timing counts
package tfbf_pkg;

	localparam int WORD_W = 8;

	// Control word bit positions
	localparam int CB_WD_UNDERCUR = 7;
	localparam int CB_ARM_FAIL    = 6;
	localparam int CB_HS_ON       = 5;
	localparam int CB_HS_CYCLIC   = 4;
	localparam int CB_NOT_STBY    = 3;
	localparam int CB_TX_EN       = 2;
	localparam int CB_CLR_WAKE    = 1;
	localparam int CB_WD_TRIG     = 0;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DIAG_RESET = 8'h00;

	// Timing, system clock 20 MHz
	localparam int CLK_HZ          = 20000000;
	localparam int FILT_ON_US      = 30;
	localparam int FILT_OFF_US     = 30;
	localparam int DOM_TIMEOUT_US  = 1300;
	localparam int FILT_ON_CYC  = (FILT_ON_US * (CLK_HZ / 1000000));
	localparam int FILT_OFF_CYC = (FILT_OFF_US * (CLK_HZ / 1000000));
	localparam int DOM_TO_CYC   = (DOM_TIMEOUT_US * (CLK_HZ / 1000000));
	localparam int CNT_W = 16;

	// Operating modes, Gray order along the usual path
	typedef enum logic [1:0] {
		MODE_SLEEP   = 2'b00,
		MODE_STANDBY = 2'b01,
		MODE_LISTEN  = 2'b11,
		MODE_NORMAL  = 2'b10
	} tfbf_mode_type;

	// Comparator inputs: differential, four per line, plus lines shorted
	typedef struct packed {
		logic diffOk;
		logic highOpen;
		logic highShortBat;
		logic highShortVcc;
		logic highShortGnd;
		logic lowOpen;
		logic lowShortBat;
		logic lowShortVcc;
		logic lowShortGnd;
		logic linesShorted;
	} tfbf_cmp_type;

	// Latched failure groups
	typedef struct packed {
		logic g54_7;
		logic g6_3;
		logic g6a_3a;
		logic g21_45;
		logic g3_6;
		logic g12_3a6a;
	} tfbf_fail_type;

	typedef struct packed {
		logic hsUvTemp;
		logic hsOvercur;
		logic wdReset;
		logic tempWarn;
		logic vccFail;
		logic vintFail;
		logic wakeInitFail;
		logic wakeBus;
	} tfbf_stat_type;

endpackage : tfbf_pkg

// ===== src/tfbf_core.sv
// Purpose: Serial control port, mode selection and bus fault handling
// Assumes: Serial clock idles low, data sampled on its rising edge
// Notes:   Serial shifter runs on the link clock, word capture on chip_select_n rising, the rest on clock
//
// Operation
// - Master shifts an eight-bit control word on serial_in with its clock.
// - A frame starts when chip_select_n falls.
// - Shifted word becomes control word only at chip_select_n rising.
// - serial_out released to high impedance while chip_select_n is high.
// - Diagnosis depends on mode; standby latches clear when leaving standby.
// - Control bits: watchdog, fail arm, switch, mode, wake clear, trigger.
// - Normal diagnosis: switch faults, line faults, wake levels, watchdog.
// - Listen-only diagnosis: failure groups, watchdog reset, temperature warning.
// - Standby diagnosis: supply fails, wake init fail, bus wake, levels.
// - Normal mode reports high-line fault bit 4, low-line fault bit 5.
// - Failure indications held until the next frame transmission starts.
// - Wiring fault switches to single-wire mode on the healthy line.
// - Single-wire entered after filter delay, left after further delay.
// - Failures 3,5,6,6a,7 disable affected line and steer receiver.
// - Failures 1,2,3a,4 keep differential receiver with both lines.
// - Dominant transmit input beyond timeout disables both transmitters.
// - Thermal shutdown keeps reception and receive output alive.
// - Listen-only disables output stages, no acknowledge driven.
// - Low termination to regulator in normal/listen, else battery.
// - Mode chosen from control bits 3 and 2.
// - Undervoltage or watchdog reset clears all control bits.
`timescale 1ns/1ps
module tfbf_core
	import tfbf_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic               serialClock,
	input  wire logic               chip_select_n,
	input  wire logic               serial_in,
	output logic                    serialOut,
	output logic                    serialOutEnN,
	input  wire logic               transmitDataIn,
	output logic                    receiveDataOut,
	input  wire tfbf_cmp_type       cmpIn,
	input  wire tfbf_stat_type      statIn,
	input  wire logic               wake_input_a,
	input  wire logic               wake_input_b,
	input  wire logic               thermalShutdown,
	input  wire logic               supplyReset,
	output logic                    highTxEn,
	output logic                    lowTxEn,
	output logic                    highTermEn,
	output logic                    lowTermEn,
	output logic                    lowTermToBattery,
	output logic                    highTermToGround,
	output logic                    rxSingleHigh,
	output logic                    rxSingleLow,
	output logic [WORD_W-1:0]       controlWord,
	output tfbf_mode_type           modeOut
);

////////////////////////////////////////////////////////////////////////////////
// Link domain: shifter, runs only while the master clocks
typedef struct packed {
	logic [7:0] shiftIn;
	logic [7:0] shiftOut;
	logic       loadDone;
} tfbf_link_type;

// Captured word lives apart: only the closing edge clocks it
typedef struct packed {
	logic [7:0] word;
	logic       wordTog;
} tfbf_cap_type;

tfbf_link_type link_ff, nxt_link;
tfbf_cap_type  cap_ff, nxt_cap;
logic [7:0]    diagSnap;
logic          outOn;

// Diagnosis snapshot from system domain, stable during a frame
always_comb begin
	nxt_link = link_ff;
	if (!link_ff.loadDone) begin
		nxt_link.shiftOut = {diagSnap[6:0], 1'b0};
		nxt_link.loadDone = 1'b1;
	end else begin
		nxt_link.shiftOut = {link_ff.shiftOut[6:0], 1'b0};
	end
	nxt_link.shiftIn = {link_ff.shiftIn[6:0], serial_in};
end

// Frame bookkeeping resets on chip_select_n high
always_ff @(posedge serialClock or posedge chip_select_n) begin
	if (chip_select_n) begin
		link_ff.shiftIn  <= 8'h00;
		link_ff.shiftOut <= 8'h00;
		link_ff.loadDone <= 1'b0;
	end else begin
		link_ff.shiftIn  <= nxt_link.shiftIn;
		link_ff.shiftOut <= nxt_link.shiftOut;
		link_ff.loadDone <= nxt_link.loadDone;
	end
end

// Word capture on the closing edge; toggle tells system domain
always_ff @(posedge chip_select_n or posedge sys_rst) begin
	if (sys_rst) begin
		cap_ff <= '0;
	end else begin
		cap_ff <= nxt_cap;
	end
end

always_comb begin
	nxt_cap.word    = link_ff.shiftIn;
	nxt_cap.wordTog = ~cap_ff.wordTog;
end

// First bit must show before the first clock edge
always_comb begin
	outOn = !chip_select_n;
	serialOut = link_ff.loadDone ? link_ff.shiftOut[7] : diagSnap[7];
	serialOutEnN = !outOn;
end

////////////////////////////////////////////////////////////////////////////////
// System domain state
typedef struct packed {
	logic [2:0]    togSync;
	logic [7:0]    ctrl;
	logic [7:0]    diag;
	tfbf_mode_type mode;
	tfbf_fail_type fail;
	logic          hiFault;
	logic          loFault;
	logic          singleHigh;
	logic          singleLow;
	logic [CNT_W-1:0] filtCnt;
	logic [CNT_W-1:0] domCnt;
	logic          domBlock;
	logic [1:0]    txSync;
	logic          txPrev;
	logic          standbyWake;
	logic          standbyInit;
	logic          wakeLatch;
} tfbf_state_type;

tfbf_state_type st_ff, nxt_st;
tfbf_fail_type  failNow;
logic           hiAffect;
logic           loAffect;
logic           anyFault;
logic           frameStart;
logic           csActive;
logic [1:0]     wakeLvl;
logic           thermalHot;

// Select, wake and thermal pin levels pass two flip-flops before system logic reads them
tfbf_sync #(
	.W (1)
) csSync (
	.clock   (clock),
	.sys_rst (sys_rst),
	.din     (~chip_select_n),
	.dout    (csActive)
);

tfbf_sync #(
	.W (2)
) wakeSync (
	.clock   (clock),
	.sys_rst (sys_rst),
	.din     ({wake_input_b, wake_input_a}),
	.dout    (wakeLvl)
);

tfbf_sync #(
	.W (1)
) hotSync (
	.clock   (clock),
	.sys_rst (sys_rst),
	.din     (thermalShutdown),
	.dout    (thermalHot)
);

always_comb begin
	// Failure classes from the comparators; bracketed numbers name them
	failNow.g54_7    = cmpIn.lowShortGnd | cmpIn.linesShorted;
	failNow.g6_3     = cmpIn.highShortBat;
	failNow.g6a_3a   = cmpIn.highShortVcc;
	failNow.g21_45   = cmpIn.highOpen | cmpIn.highShortGnd;
	failNow.g3_6     = cmpIn.lowShortBat;
	failNow.g12_3a6a = cmpIn.lowOpen | cmpIn.lowShortVcc;
	// Only these groups cost a line; the rest stay differential
	hiAffect = failNow.g6_3 | failNow.g6a_3a;
	loAffect = failNow.g3_6 | failNow.g54_7;
	anyFault = hiAffect | loAffect;
end

always_comb begin
	nxt_st = st_ff;
	nxt_st.togSync = {st_ff.togSync[1:0], cap_ff.wordTog};
	nxt_st.txSync  = {st_ff.txSync[0], transmitDataIn};
	nxt_st.txPrev  = st_ff.txSync[1];
	// Recessive to dominant marks the start of a frame
	frameStart = st_ff.txPrev & ~st_ff.txSync[1];

	// New control word after the closing edge crosses
	if (st_ff.togSync[2] != st_ff.togSync[1]) begin
		nxt_st.ctrl = cap_ff.word;
		if (cap_ff.word[CB_CLR_WAKE]) begin
			nxt_st.wakeLatch = 1'b0;
		end
	end
	if (supplyReset | statIn.wdReset) begin
		nxt_st.ctrl = CTRL_RESET;
	end

	case ({nxt_st.ctrl[CB_NOT_STBY], nxt_st.ctrl[CB_TX_EN]})
		2'b11:   nxt_st.mode = MODE_NORMAL;
		2'b10:   nxt_st.mode = MODE_LISTEN;
		2'b01:   nxt_st.mode = MODE_STANDBY;
		default: nxt_st.mode = MODE_SLEEP;
	endcase

	// Filtered entry and exit of single-wire operation
	if (anyFault != (st_ff.singleHigh | st_ff.singleLow)) begin
		nxt_st.filtCnt = st_ff.filtCnt + 16'h0001;
		if (anyFault && st_ff.filtCnt >= CNT_W'(FILT_ON_CYC - 1)) begin
			nxt_st.singleHigh = loAffect;
			nxt_st.singleLow  = hiAffect;
			nxt_st.filtCnt    = 16'h0000;
		end else if (!anyFault &&
		             st_ff.filtCnt >= CNT_W'(FILT_OFF_CYC - 1)) begin
			nxt_st.singleHigh = 1'b0;
			nxt_st.singleLow  = 1'b0;
			nxt_st.filtCnt    = 16'h0000;
		end
	end else begin
		nxt_st.filtCnt = 16'h0000;
	end

	// Fault flags sticky until the next frame starts; new fault wins
	if (frameStart) begin
		nxt_st.fail    = failNow;
		nxt_st.hiFault = hiAffect | failNow.g21_45;
		nxt_st.loFault = loAffect | failNow.g12_3a6a;
	end else begin
		nxt_st.fail    = st_ff.fail | failNow;
		nxt_st.hiFault = st_ff.hiFault | hiAffect | failNow.g21_45;
		nxt_st.loFault = st_ff.loFault | loAffect | failNow.g12_3a6a;
	end

	// Dominant timeout; released on recessive
	if (!st_ff.txSync[1]) begin
		if (st_ff.domCnt >= CNT_W'(DOM_TO_CYC)) begin
			nxt_st.domBlock = 1'b1;
		end else begin
			nxt_st.domCnt = st_ff.domCnt + 16'h0001;
		end
	end else begin
		nxt_st.domCnt   = 16'h0000;
		nxt_st.domBlock = 1'b0;
	end

	// Standby latches, cleared when leaving standby
	if (nxt_st.mode == MODE_STANDBY) begin
		nxt_st.standbyWake = st_ff.standbyWake | statIn.wakeBus;
		nxt_st.standbyInit = st_ff.standbyInit | statIn.wakeInitFail;
		nxt_st.wakeLatch   = nxt_st.wakeLatch | statIn.wakeBus;
	end else begin
		nxt_st.standbyWake = 1'b0;
		nxt_st.standbyInit = 1'b0;
		nxt_st.wakeLatch   = 1'b0;
	end

	nxt_st.diag = DIAG_RESET;
	case (st_ff.mode)
		MODE_NORMAL: begin
			nxt_st.diag[7]   = statIn.hsUvTemp;
			nxt_st.diag[6]   = statIn.hsOvercur;
			nxt_st.diag[5]   = st_ff.loFault;
			nxt_st.diag[4]   = st_ff.hiFault;
			nxt_st.diag[3:2] = wakeLvl;
			nxt_st.diag[1]   = statIn.wdReset;
			nxt_st.diag[0]   = statIn.tempWarn;
		end
		MODE_LISTEN: begin
			nxt_st.diag[7]   = st_ff.fail.g54_7;
			nxt_st.diag[6]   = st_ff.fail.g6_3;
			nxt_st.diag[5]   = st_ff.fail.g6a_3a;
			nxt_st.diag[4]   = st_ff.fail.g21_45;
			nxt_st.diag[3]   = st_ff.fail.g3_6;
			nxt_st.diag[2]   = st_ff.fail.g12_3a6a;
			nxt_st.diag[1]   = statIn.wdReset;
			nxt_st.diag[0]   = statIn.tempWarn;
		end
		MODE_STANDBY: begin
			// Not-failed bits read low until control bit 6 arms them
			nxt_st.diag[7]   = ~statIn.vccFail & st_ff.ctrl[CB_ARM_FAIL];
			nxt_st.diag[6]   = ~statIn.vintFail & st_ff.ctrl[CB_ARM_FAIL];
			nxt_st.diag[5]   = st_ff.standbyInit;
			nxt_st.diag[4]   = st_ff.standbyWake;
			nxt_st.diag[3:2] = wakeLvl;
			nxt_st.diag[1]   = statIn.wdReset;
			nxt_st.diag[0]   = statIn.tempWarn;
		end
		default: begin
			nxt_st.diag = DIAG_RESET;
		end
	endcase
	// Frozen while a frame is open; a status change within two
	// clocks of the select edge may still tear the first bits
	if (csActive) begin
		nxt_st.diag = st_ff.diag;
	end
end

always_ff @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		st_ff <= '0;
	end else begin
		st_ff <= nxt_st;
	end
end

assign diagSnap = st_ff.diag;

////////////////////////////////////////////////////////////////////////////////
// Line stages, receiver path and terminations
logic txAllowed;
always_comb begin
	// Thermal cut touches only drivers, never the receive path
	txAllowed = (st_ff.mode == MODE_NORMAL) & ~st_ff.domBlock
	            & ~thermalHot;
	highTxEn  = txAllowed & ~st_ff.singleLow;
	lowTxEn   = txAllowed & ~st_ff.singleHigh;
	highTermEn = ~st_ff.singleLow;
	lowTermEn  = ~st_ff.singleHigh;
	rxSingleHigh = st_ff.singleHigh;
	rxSingleLow  = st_ff.singleLow;
	receiveDataOut = (st_ff.mode == MODE_NORMAL || st_ff.mode == MODE_LISTEN)
	                 ? cmpIn.diffOk : ~st_ff.wakeLatch;
	lowTermToBattery = !(st_ff.mode == MODE_NORMAL ||
	                     st_ff.mode == MODE_LISTEN);
	highTermToGround = 1'b1;
	controlWord = st_ff.ctrl;
	modeOut     = st_ff.mode;
end

endmodule : tfbf_core

////////////////////////////////////////////////////////////////////////////////
// Two flip-flop synchroniser for levels from pins or the link domain
module tfbf_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

logic [2*W-1:0] sync_ff;
logic [2*W-1:0] nxt_sync;

always_comb begin
	nxt_sync = {sync_ff[W-1:0], din};
end

always_ff @(posedge clock or posedge sys_rst) begin
	if (sys_rst) begin
		sync_ff <= '0;
	end else begin
		sync_ff <= nxt_sync;
	end
end

// Only the second stage leaves, the first may be metastable
assign dout = sync_ff[2*W-1:W];

endmodule : tfbf_sync

// ===== test/tfbf_core_properties.sv
// Purpose: Port-level assertions for the transceiver control logic
// Assumes: Everything checked here lives in the system clock domain
// Notes:   Counters stand in for long repetitions
`timescale 1ns/1ps
module tfbf_core_properties
	import tfbf_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          chip_select_n,
	input  wire logic          serialOutEnN,
	input  wire logic          transmitDataIn,
	input  wire logic          receiveDataOut,
	input  wire tfbf_cmp_type  cmpIn,
	input  wire tfbf_stat_type statIn,
	input  wire logic          thermalShutdown,
	input  wire logic          supplyReset,
	input  wire logic          highTxEn,
	input  wire logic          lowTxEn,
	input  wire logic          lowTermToBattery,
	input  wire logic          highTermToGround,
	input  wire logic          rxSingleHigh,
	input  wire logic          rxSingleLow,
	input  wire logic [7:0]    controlWord,
	input  wire tfbf_mode_type modeOut
);
	logic [2:0]       csLowCnt_ff;
	logic [CNT_W-1:0] domCnt_ff;

	// Saturating, so a stuck input cannot wrap and hide a fault
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			csLowCnt_ff <= 3'h0;
			domCnt_ff <= '0;
		end else begin
			csLowCnt_ff <= chip_select_n ? 3'h0 :
				csLowCnt_ff + 3'(csLowCnt_ff != 3'h7);
			domCnt_ff <= transmitDataIn ? '0 :
				domCnt_ff + CNT_W'(domCnt_ff != '1);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_oe_tracks_cs: assert property (serialOutEnN == chip_select_n)
		else $error("output enable differs from chip select");
	a_ctrl_held_frame: assert property (csLowCnt_ff == 3'h7 && !supplyReset
		&& !statIn.wdReset |-> $stable(controlWord))
		else $error("control word changed inside a frame");
	a_ctrl_reset_zero: assert property (supplyReset
		|-> ##[1:4] controlWord == 8'h00)
		else $error("control word not cleared by supply reset");
	a_listen_quiet: assert property (modeOut == MODE_LISTEN
		|-> !highTxEn && !lowTxEn)
		else $error("transmitter enabled in listen mode");
	a_term_supply: assert property (highTermToGround && lowTermToBattery ==
		(modeOut == MODE_SLEEP || modeOut == MODE_STANDBY))
		else $error("termination switched to the wrong supply");
	a_mode_normal_sel: assert property ($changed(controlWord)
		&& controlWord[3:2] == 2'b11 |-> ##[0:2] modeOut == MODE_NORMAL)
		else $error("normal mode not taken from control bits");
	a_dom_cutoff: assert property (domCnt_ff >= DOM_TO_CYC + 4
		|-> !highTxEn && !lowTxEn)
		else $error("dominant timeout did not cut transmitters");
	a_rx_diff_live: assert property (modeOut == MODE_NORMAL && !rxSingleHigh
		&& !rxSingleLow |-> receiveDataOut == cmpIn.diffOk)
		else $error("receive output does not follow the bus");
	a_thermal_tx_off: assert property (thermalShutdown[*3]
		|-> !highTxEn && !lowTxEn)
		else $error("transmitter enabled in thermal shutdown");
endmodule : tfbf_core_properties

// ===== test/tfbf_spi_master.sv
// Purpose: Serial master model for the control port
// Assumes: Clock idles low between frames, data taken on its rising edge
// Notes:   Released data line shows the inverted last bit, not a copy
`timescale 1ns/1ps
module tfbf_spi_master (
	output logic      serialClock,
	output logic      chip_select_n,
	output logic      serial_in,
	input  wire logic serialOut,
	input  wire logic serialOutEnN
);
	initial begin
		serialClock = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
	end

	// Full 125 ns bit time, MSB first
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		chip_select_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			serial_in = tx[i];
			#31.25;
			rx[i] = serialOutEnN ? 1'bx : serialOut;
			#31.25 serialClock = 1'b1;
			#62.5 serialClock = 1'b0;
		end
		#62.5 chip_select_n = 1'b1;
		serial_in = ~serial_in;
	endtask : xfer
endmodule : tfbf_spi_master

// ===== test/tfbf_core_tb_top.sv
// Purpose: Self-checking bench for the transceiver control logic
// Assumes: Master model makes the link clock within frames only
// Notes:   Full filter and timeout counts, run is about 1.4 ms
`timescale 1ns/1ps
module tfbf_core_tb_top
	import tfbf_pkg::*;
;
	logic          clock = 1'b0;
	logic          sys_rst, transmitDataIn, wake_input_a, wake_input_b;
	logic          thermalShutdown, supplyReset;
	tfbf_cmp_type  cmpIn;
	tfbf_stat_type statIn;
	logic          serialClock, chip_select_n, serial_in, serialOut;
	logic          serialOutEnN, receiveDataOut, highTxEn, lowTxEn;
	logic          highTermEn, lowTermEn, lowTermToBattery;
	logic          highTermToGround, rxSingleHigh, rxSingleLow;
	logic [7:0]    controlWord, rd;
	tfbf_mode_type modeOut;
	tfbf_mode_type modeTab [4] = '{MODE_SLEEP, MODE_STANDBY, MODE_LISTEN,
		MODE_NORMAL};
	int            n_errors = 0;
	int            cmp_count = 0;

	always #25 clock = ~clock;

	tfbf_core dut (.clock, .sys_rst, .serialClock, .chip_select_n,
		.serial_in, .serialOut, .serialOutEnN, .transmitDataIn,
		.receiveDataOut, .cmpIn, .statIn, .wake_input_a, .wake_input_b,
		.thermalShutdown, .supplyReset, .highTxEn, .lowTxEn, .highTermEn,
		.lowTermEn, .lowTermToBattery, .highTermToGround, .rxSingleHigh,
		.rxSingleLow, .controlWord, .modeOut);
	tfbf_spi_master spi (.serialClock, .chip_select_n, .serial_in,
		.serialOut, .serialOutEnN);

	////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Gap after the frame covers the word's crossing into clock
	task xf(input logic [7:0] w);
		spi.xfer(w, rd);
		cyc(8);
	endtask : xf
	task report_and_stop;
		$display("mismatches %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	initial begin
		#4_000_000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		{sys_rst, transmitDataIn, wake_input_b} = 3'b111;
		{wake_input_a, thermalShutdown, supplyReset} = 3'b000;
		cmpIn = '0;
		cmpIn.diffOk = 1'b1;
		statIn = '0;
		cyc(4);
		sys_rst = 1'b0;
		cyc(2);
		chk(controlWord, 8'h00);
		for (int i = 0; i < 4; i++) begin
			xf({4'h0, 2'(i), 2'b00});
			chk(controlWord, {4'h0, 2'(i), 2'b00});
			chk({6'h0, modeOut}, {6'h0, modeTab[i]});
			chk(lowTermToBattery, 1'(i < 2));
		end
		chk(serialOutEnN, 1'b1);
		statIn.hsUvTemp = 1'b1;
		statIn.tempWarn = 1'b1;
		xf(8'h0C);
		chk(rd, 8'h89);
		statIn = '0;
		cmpIn.highShortGnd = 1'b1;
		cyc(FILT_ON_CYC + 20);
		chk({highTxEn, lowTxEn, rxSingleHigh, rxSingleLow}, 4'hC);
		xf(8'h0C);
		chk(rd, 8'h18);
		cmpIn.highShortGnd = 1'b0;
		cmpIn.lowShortGnd = 1'b1;
		cyc(FILT_ON_CYC / 2);
		chk(lowTxEn, 1'b1);
		cyc(FILT_ON_CYC);
		chk({lowTxEn, lowTermEn, rxSingleHigh}, 3'b001);
		xf(8'h08);
		chk(rd, 8'h38);
		chk({highTxEn, lowTxEn}, 2'b00);
		xf(8'h08);
		chk(rd, 8'h90);
		cmpIn.lowShortGnd = 1'b0;
		cyc(FILT_OFF_CYC + 20);
		xf(8'h0C);
		chk({lowTxEn, rxSingleHigh}, 2'b10);
		transmitDataIn = 1'b0;
		cyc(4);
		transmitDataIn = 1'b1;
		cyc(4);
		xf(8'h0C);
		chk(rd, 8'h08);
		thermalShutdown = 1'b1;
		cyc(4);
		chk({highTxEn, lowTxEn}, 2'b00);
		cmpIn.diffOk = 1'b0;
		cyc(1);
		chk(receiveDataOut, 1'b0);
		cmpIn.diffOk = 1'b1;
		cyc(1);
		chk(receiveDataOut, 1'b1);
		thermalShutdown = 1'b0;
		transmitDataIn = 1'b0;
		cyc(DOM_TO_CYC - 10);
		chk(highTxEn, 1'b1);
		cyc(20);
		chk({highTxEn, lowTxEn}, 2'b00);
		transmitDataIn = 1'b1;
		xf(8'h44);
		xf(8'h44);
		chk(rd, 8'hC8);
		supplyReset = 1'b1;
		cyc(2);
		supplyReset = 1'b0;
		cyc(4);
		chk(controlWord, 8'h00);
		report_and_stop();
	end
endmodule : tfbf_core_tb_top

bind tfbf_core tfbf_core_properties props (.clock, .sys_rst, .chip_select_n,
	.serialOutEnN, .transmitDataIn, .receiveDataOut, .cmpIn, .statIn,
	.thermalShutdown, .supplyReset, .highTxEn, .lowTxEn, .lowTermToBattery,
	.highTermToGround, .rxSingleHigh, .rxSingleLow, .controlWord, .modeOut);
